// ### inc/acs_defines.vh
/*
 * Constants for the converter sequencer: register offsets, field positions,
 * reset values, format codes and conversion length.
 * Assumes a byte-wide register port with a 2-bit address.
 */
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define ACS_ADDR_W 2
`define ACS_OFF_SC 2'h0
`define ACS_OFF_RHI 2'h1
`define ACS_OFF_RLO 2'h2
`define ACS_OFF_CLK 2'h3

// ****************************************
// Status and control fields
// ****************************************
`define ACS_SC_FLAG_BIT 7
`define ACS_SC_CONT_BIT 5
`define ACS_SC_CH_MSB 4
`define ACS_SC_CH_LSB 0
`define ACS_SC_RESET 8'h00

// ****************************************
// Clock register fields
// ****************************************
`define ACS_CK_DIV_MSB 7
`define ACS_CK_DIV_LSB 5
`define ACS_CK_SRC_BIT 4
`define ACS_CK_FMT_HI_BIT 3
`define ACS_CK_FMT_LO_BIT 2
`define ACS_CK_RESET 8'h00

// ****************************************
// Result formats
// ****************************************
`define ACS_FMT_LEFT 2'h0
`define ACS_FMT_RIGHT 2'h1
`define ACS_FMT_LSIGN 2'h2
`define ACS_FMT_TRUNC 2'h3

// ****************************************
// Conversion length in converter clocks
// ****************************************
`define ACS_CONV_TICKS 5'h10
`define ACS_CNT_W 5
`define ACS_DIV_W 8

`endif

// ### verilog/acs_result_store.v
/*
 * Result store: formats a 10-bit result into high and low data bytes.
 * Assumes the caller pulses load only when a store is allowed.
 */
`include "acs_defines.vh"

module acs_result_store #(
	parameter RES_W = 10
) (
	input wire sys_clk,
	input wire reset,
	input wire load,
	input wire [1:0] fmt,
	input wire [RES_W-1:0] result,
	output reg [7:0] high_r,
	output reg [7:0] low_r
);

	reg [7:0] high_nxt;
	reg [7:0] low_nxt;

	// ****************************************
	// Justification
	// ****************************************
	always @* begin
		high_nxt = 8'h00;
		low_nxt = 8'h00;
		case (fmt)
			`ACS_FMT_LEFT: begin
				high_nxt = result[9:2]; // [RULE10]
				low_nxt = {result[1:0], 6'h00}; // [RULE16]
			end
			`ACS_FMT_RIGHT: begin
				high_nxt = {6'h00, result[9:8]}; // [RULE12] [RULE16]
				low_nxt = result[7:0]; // [RULE12]
			end
			`ACS_FMT_LSIGN: begin
				high_nxt = {~result[9], result[8:2]}; // [RULE13]
				low_nxt = {result[1:0], 6'h00}; // [RULE13]
			end
			`ACS_FMT_TRUNC: begin
				high_nxt = 8'h00; // [RULE16]
				low_nxt = result[9:2]; // [RULE14]
			end
			default: begin
				high_nxt = 8'h00;
				low_nxt = 8'h00;
			end
		endcase
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			high_r <= 8'h00;
			low_r <= 8'h00;
		end else if (load) begin
			high_r <= high_nxt;
			low_r <= low_nxt;
		end
	end

endmodule

// ### verilog/acs_sequencer.v
/*
 * Conversion sequencer for a 10-bit successive-approximation core:
 * register port, converter clock divider, single and continuous
 * sequencing, completion flag and read-order interlock.
 * Assumes the analog core samples core_result stable at the end of a
 * conversion and advances one step per core_tick.
 */
// The placing of the registers and the strobed register port are this design's own decisions.
`include "acs_defines.vh"

// Function
// RULE1: Status/control write starts a conversion
// RULE2: Conversion lasts 16 to 17 converter clocks
// RULE3: Software should set converter clock to 1 MHz
// RULE4: Continuous mode overwrites unread results
// RULE5: Continuous mode restarts while continuous bit set
// RULE6: Complete flag set, cleared by data read
// RULE7: Single mode: one conversion per write
// RULE8: Software discards results of interrupted conversions
// RULE9: Four formats chosen by two select bits
// RULE10: Left: top eight bits high, two low
// RULE11: Left: high read locks until low read
// RULE12: Right: two top bits high, eight low
// RULE13: Signed left: top result bit inverted
// RULE14: Truncation: top eight bits in low byte
// RULE15: Format codes 00,01,10,11 in that order
// RULE16: Unused data bits read zero
module acs_sequencer #(
	parameter RES_W = 10,
	parameter CH_W = 5
) (
	input wire sys_clk,
	input wire reset,
	input wire [`ACS_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_r,
	input wire conv_ext_clk,
	input wire [RES_W-1:0] core_result,
	output wire core_tick,
	output reg core_start_r,
	output reg core_busy_r,
	output reg [CH_W-1:0] core_channel_r
);

	// ****************************************
	// States
	// ****************************************
	localparam ST_IDLE = 2'h0;
	localparam ST_ARM = 2'h1;
	localparam ST_RUN = 2'h2;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [`ACS_CNT_W-1:0] cnt_r;
	reg [`ACS_CNT_W-1:0] cnt_nxt;

	// ****************************************
	// Register state
	// ****************************************
	reg continuous_convert_bit_r;
	reg conversion_complete_flag_r;
	reg [2:0] conv_clock_divide_bits_r;
	reg conv_clock_source_select_r;
	reg format_select_hi_r;
	reg format_select_lo_r;
	reg lock_r;
	reg lock_nxt;
	reg flag_nxt;

	wire [1:0] fmt = {format_select_hi_r, format_select_lo_r}; // [RULE9] [RULE15]
	wire left_fmt = (fmt == `ACS_FMT_LEFT) || (fmt == `ACS_FMT_LSIGN);

	wire wr_sc = reg_wr && (reg_addr == `ACS_OFF_SC);
	wire wr_clk = reg_wr && (reg_addr == `ACS_OFF_CLK);
	wire rd_hi = reg_rd && (reg_addr == `ACS_OFF_RHI);
	wire rd_lo = reg_rd && (reg_addr == `ACS_OFF_RLO);

	wire [7:0] result_high_reg;
	wire [7:0] result_low_reg;

	// ****************************************
	// External clock pin synchroniser
	// ****************************************
	// Third stage only confirms the second, so a runt pulse is ignored
	reg ext_s1_r;
	reg ext_s2_r;
	reg ext_s3_r;
	reg ext_lvl_r;
	reg ext_lvl_nxt;
	wire ext_rise = ext_lvl_nxt && !ext_lvl_r;

	always @* begin
		ext_lvl_nxt = ext_lvl_r;
		if (ext_s2_r == ext_s3_r) begin
			ext_lvl_nxt = ext_s2_r;
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			ext_lvl_r <= 1'b0;
		end else begin
			ext_s1_r <= conv_ext_clk;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			ext_lvl_r <= ext_lvl_nxt;
		end
	end

	// ****************************************
	// Converter clock divider
	// ****************************************
	// Divide by a power of two; the rate itself is software's to choose
	reg [`ACS_DIV_W-1:0] div_r;
	wire src_pulse = conv_clock_source_select_r ? ext_rise : 1'b1;
	wire [`ACS_DIV_W-1:0] div_last =
		(({{(`ACS_DIV_W-1){1'b0}}, 1'b1}) << conv_clock_divide_bits_r) - 1'b1;
	wire div_wrap = src_pulse && (div_r >= div_last);

	assign core_tick = div_wrap;

	always @(posedge sys_clk) begin
		if (reset) begin
			div_r <= {`ACS_DIV_W{1'b0}};
		end else if (div_wrap) begin
			div_r <= {`ACS_DIV_W{1'b0}};
		end else if (src_pulse) begin
			div_r <= div_r + 1'b1;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	// Start waits for the next converter clock, hence one clock of spread
	wire conv_end = (state_r == ST_RUN) && core_tick && (cnt_r == `ACS_CONV_TICKS);
	wire store_ok = !(left_fmt && lock_r); // [RULE11]
	wire store = conv_end && !wr_sc && store_ok;

	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			ST_IDLE: begin
				cnt_nxt = {`ACS_CNT_W{1'b0}};
			end
			ST_ARM: begin
				if (core_tick) begin
					state_nxt = ST_RUN;
					cnt_nxt = {{(`ACS_CNT_W-1){1'b0}}, 1'b1};
				end
			end
			ST_RUN: begin
				if (core_tick) begin
					if (cnt_r == `ACS_CONV_TICKS) begin // [RULE2]
						cnt_nxt = {`ACS_CNT_W{1'b0}};
						if (continuous_convert_bit_r) begin
							state_nxt = ST_ARM; // [RULE5]
						end else begin
							state_nxt = ST_IDLE; // [RULE7]
						end
					end else begin
						cnt_nxt = cnt_r + 1'b1;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt = {`ACS_CNT_W{1'b0}};
			end
		endcase
		if (wr_sc) begin
			// Rewrite aborts any conversion in flight and starts afresh
			state_nxt = ST_ARM; // [RULE1] [RULE8]
			cnt_nxt = {`ACS_CNT_W{1'b0}};
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			cnt_r <= {`ACS_CNT_W{1'b0}};
			core_start_r <= 1'b0;
			core_busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			core_start_r <= (state_r == ST_ARM) && core_tick && !wr_sc;
			core_busy_r <= (state_nxt != ST_IDLE);
		end
	end

	// ****************************************
	// Flag and interlock
	// ****************************************
	always @* begin
		flag_nxt = conversion_complete_flag_r;
		if (rd_hi || rd_lo) begin
			flag_nxt = 1'b0;
		end
		if (conv_end && !wr_sc) begin
			flag_nxt = 1'b1; // [RULE6]
		end
		lock_nxt = lock_r;
		if (rd_hi && left_fmt) begin
			lock_nxt = 1'b1; // [RULE11]
		end
		if (rd_lo || !left_fmt) begin
			lock_nxt = 1'b0; // [RULE11]
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			conversion_complete_flag_r <= 1'b0;
			lock_r <= 1'b0;
		end else begin
			conversion_complete_flag_r <= flag_nxt;
			lock_r <= lock_nxt;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	wire [7:0] sc_reset = `ACS_SC_RESET;

	always @(posedge sys_clk) begin
		if (reset) begin
			continuous_convert_bit_r <= sc_reset[`ACS_SC_CONT_BIT];
			core_channel_r <= {CH_W{1'b0}};
			conv_clock_divide_bits_r <= 3'h0;
			conv_clock_source_select_r <= 1'b0;
			format_select_hi_r <= 1'b0;
			format_select_lo_r <= 1'b0;
		end else begin
			if (wr_sc) begin
				continuous_convert_bit_r <= reg_wdata[`ACS_SC_CONT_BIT];
				core_channel_r <= reg_wdata[`ACS_SC_CH_MSB:`ACS_SC_CH_LSB];
			end
			if (wr_clk) begin
				conv_clock_divide_bits_r <= reg_wdata[`ACS_CK_DIV_MSB:`ACS_CK_DIV_LSB];
				conv_clock_source_select_r <= reg_wdata[`ACS_CK_SRC_BIT];
				format_select_hi_r <= reg_wdata[`ACS_CK_FMT_HI_BIT]; // [RULE9]
				format_select_lo_r <= reg_wdata[`ACS_CK_FMT_LO_BIT]; // [RULE9]
			end
		end
	end

	// ****************************************
	// Result storage
	// ****************************************
	// Continuous results overwrite unread data unless the lock holds
	acs_result_store #(
		.RES_W(RES_W)
	) u_store (
		.sys_clk(sys_clk),
		.reset(reset),
		.load(store), // [RULE4]
		.fmt(fmt),
		.result(core_result),
		.high_r(result_high_reg),
		.low_r(result_low_reg)
	);

	// ****************************************
	// Read port
	// ****************************************
	reg [7:0] rdata_nxt;

	always @* begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			`ACS_OFF_SC: begin
				rdata_nxt[`ACS_SC_FLAG_BIT] = conversion_complete_flag_r;
				rdata_nxt[`ACS_SC_CONT_BIT] = continuous_convert_bit_r;
				rdata_nxt[`ACS_SC_CH_MSB:`ACS_SC_CH_LSB] = core_channel_r;
			end
			`ACS_OFF_RHI: begin
				rdata_nxt = result_high_reg;
			end
			`ACS_OFF_RLO: begin
				rdata_nxt = result_low_reg;
			end
			`ACS_OFF_CLK: begin
				rdata_nxt[`ACS_CK_DIV_MSB:`ACS_CK_DIV_LSB] = conv_clock_divide_bits_r;
				rdata_nxt[`ACS_CK_SRC_BIT] = conv_clock_source_select_r;
				rdata_nxt[`ACS_CK_FMT_HI_BIT] = format_select_hi_r;
				rdata_nxt[`ACS_CK_FMT_LO_BIT] = format_select_lo_r;
			end
			default: begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_r <= rdata_nxt;
		end else begin
			reg_rdata_r <= 8'h00;
		end
	end

endmodule

// ### dv/acs_seq_checker.sv
/* Port checker for the converter sequencer.
   Assumes it is bound into acs_sequencer and shares its parameters. */
`include "acs_defines.vh"
module acs_seq_checker #(
	parameter RES_W = 10,
	parameter CH_W = 5
) (
	input wire sys_clk,
	input wire reset,
	input wire [`ACS_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_r,
	input wire conv_ext_clk,
	input wire [RES_W-1:0] core_result,
	input wire core_tick,
	input wire core_start_r,
	input wire core_busy_r,
	input wire [CH_W-1:0] core_channel_r
);
	timeunit 1ns;
	timeprecision 100ps;
	// ******
	// Properties
	// ******
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	wire sc_wr = reg_wr && reg_addr == `ACS_OFF_SC;
	reg cont_r;
	// Shadow of the continuous bit as last written
	always @(posedge sys_clk) begin
		if (reset)
			cont_r <= 1'b0;
		else if (sc_wr)
			cont_r <= reg_wdata[`ACS_SC_CONT_BIT];
	end
	AST_ARM: assert property (sc_wr |=> core_busy_r)
		else $error("write did not arm a conversion");
	AST_CHAN: assert property (sc_wr |=> core_channel_r == $past(reg_wdata[CH_W-1:0]))
		else $error("channel not taken from write");
	AST_PULSE: assert property (core_start_r |=> !core_start_r)
		else $error("start pulse longer than one cycle");
	AST_FIRST: assert property ($rose(core_busy_r) |-> ##[0:300] core_start_r)
		else $error("armed conversion never started");
	AST_HOLD: assert property (core_start_r |=> core_busy_r [*8])
		else $error("conversion ended far too early");
	AST_CONT: assert property (cont_r && core_busy_r |=> core_busy_r)
		else $error("continuous mode stopped");
	AST_IDLE: assert property (!cont_r && !core_busy_r && !sc_wr |=> !core_busy_r)
		else $error("single mode restarted without a write");
	AST_STBUSY: assert property (core_start_r |-> core_busy_r)
		else $error("start while idle");
	AST_RDZ: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
		else $error("read data outside its cycle");
	AST_B6: assert property ($past(reg_rd) && $past(reg_addr) == `ACS_OFF_SC
		|-> !reg_rdata_r[6])
		else $error("unused status bit reads one");
	cover property (core_start_r);
	cover property (cont_r && core_start_r);
	cover property (reg_rd && reg_addr == `ACS_OFF_RHI);
endmodule

bind acs_sequencer acs_seq_checker #(.RES_W(RES_W), .CH_W(CH_W)) acs_seq_checker_i (
	.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
	.conv_ext_clk(conv_ext_clk), .core_result(core_result), .core_tick(core_tick),
	.core_start_r(core_start_r), .core_busy_r(core_busy_r),
	.core_channel_r(core_channel_r));

// ### dv/acs_core_model.sv
/* Behavioural analog core: settles the sample ten ticks after start.
   Assumes start and tick come from the sequencer on sys_clk. */
module acs_core_model (
	input wire sys_clk,
	input wire reset,
	input wire core_tick,
	input wire core_start_r,
	input wire [9:0] sample_val,
	output wire [9:0] core_result
);
	timeunit 1ns;
	timeprecision 100ps;
	reg [3:0] step_r;
	always @(posedge sys_clk) begin
		if (reset || core_start_r)
			step_r <= 4'h0;
		else if (core_tick && step_r != 4'hA)
			step_r <= step_r + 4'h1;
	end
	// Unsettled output is inverted so an early capture shows
	assign core_result = (step_r == 4'hA) ? sample_val : ~sample_val;
endmodule

// ### dv/acs_sequencer_bench.sv
/* Bench for the converter sequencer: formats, timing, interlock,
   abort, continuous and pin-clocked runs.
   Assumes the core model and the bound checker are compiled with it. */
`include "acs_defines.vh"
module acs_sequencer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic conv_ext_clk = 1'b0;
	logic [2:0] ext_cnt = 3'h0;
	logic [9:0] sample_val = 10'h000;
	logic [7:0] d;
	wire [7:0] reg_rdata_r;
	wire [9:0] core_result;
	wire core_tick;
	wire core_start_r;
	wire core_busy_r;
	wire [4:0] core_channel_r;
	int compares = 0;
	int miscompares = 0;
	int starts = 0;
	acs_sequencer #(.RES_W(10), .CH_W(5)) acs_sequencer_i (.sys_clk(sys_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_r(reg_rdata_r), .conv_ext_clk(conv_ext_clk), .core_result(core_result),
		.core_tick(core_tick), .core_start_r(core_start_r), .core_busy_r(core_busy_r),
		.core_channel_r(core_channel_r));
	acs_core_model acs_core_model_i (.sys_clk(sys_clk), .reset(reset), .core_tick(core_tick),
		.core_start_r(core_start_r), .sample_val(sample_val), .core_result(core_result));
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		ext_cnt <= ext_cnt + 3'h1;
		if (ext_cnt == 3'h7)
			conv_ext_clk <= ~conv_ext_clk;
		if (core_start_r === 1'b1)
			starts <= starts + 1;
	end
	// ******
	// Tasks
	// ******
	task automatic end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		v = reg_rdata_r;
	endtask
	task automatic wait_done;
		logic [7:0] s;
		for (int i = 0; i < 200; i++) begin
			rd(`ACS_OFF_SC, s);
			if (s[7] === 1'b1)
				break;
		end
		chk("flag", s & 8'h80, 8'h80);
	endtask
	function automatic logic [15:0] fmt_exp(input logic [1:0] f, input logic [9:0] r);
		case (f)
			2'h0: return {r, 6'h00};
			2'h1: return {6'h00, r};
			2'h2: return {~r[9], r[8:0], 6'h00};
			default: return {8'h00, r[9:2]};
		endcase
	endfunction
	// Reads high then low, as the interlock expects
	task automatic conv(input logic [1:0] f, input logic [9:0] r);
		logic [15:0] e;
		e = fmt_exp(f, r);
		sample_val <= r;
		wr(`ACS_OFF_CLK, {4'h0, f, 2'h0});
		wr(`ACS_OFF_SC, 8'h03);
		wait_done();
		rd(`ACS_OFF_RHI, d);
		chk("high", d, e[15:8]);
		rd(`ACS_OFF_RLO, d);
		chk("low", d, e[7:0]);
	endtask
	// ******
	// Tests
	// ******
	initial begin
		int k;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		for (k = 0; k < 4; k++) begin
			rd(k[1:0], d);
			chk("reset value", d, 8'h00);
		end
		// Divide-by-1 keeps runs short; software would aim near 1 MHz
		for (k = 0; k < 8; k++)
			conv(k[1:0], k < 4 ? 10'h2C5 : 10'h13A);
		chk("channel", {3'h0, core_channel_r}, 8'h03);
		rd(`ACS_OFF_SC, d);
		chk("flag cleared", d, 8'h03);
		wr(`ACS_OFF_SC, 8'h01);
		repeat (13) @(posedge sys_clk);
		rd(`ACS_OFF_SC, d);
		chk("early flag", d, 8'h01);
		rd(`ACS_OFF_SC, d);
		chk("late flag", d, 8'h81);
		rd(`ACS_OFF_RHI, d);
		sample_val <= 10'h155;
		wr(`ACS_OFF_CLK, 8'h00);
		wr(`ACS_OFF_SC, 8'h00);
		wait_done();
		rd(`ACS_OFF_RHI, d);
		chk("locked high", d, 8'h55);
		sample_val <= 10'h2AA;
		wr(`ACS_OFF_SC, 8'h00);
		wait_done();
		rd(`ACS_OFF_RHI, d);
		chk("held high", d, 8'h55);
		rd(`ACS_OFF_RLO, d);
		chk("held low", d, 8'h40);
		conv(2'h0, 10'h2AA);
		// Rewrite mid-run; the first result must never land
		sample_val <= 10'h0F1;
		wr(`ACS_OFF_CLK, 8'h04);
		wr(`ACS_OFF_SC, 8'h00);
		repeat (3) @(posedge sys_clk);
		sample_val <= 10'h30E;
		wr(`ACS_OFF_SC, 8'h00);
		repeat (12) @(posedge sys_clk);
		rd(`ACS_OFF_SC, d);
		chk("aborted flag", d, 8'h00);
		wait_done();
		rd(`ACS_OFF_RLO, d);
		chk("restart data", d, 8'h0E);
		sample_val <= 10'h011;
		wr(`ACS_OFF_SC, 8'h20);
		wait_done();
		sample_val <= 10'h3C3;
		repeat (40) @(posedge sys_clk);
		rd(`ACS_OFF_RLO, d);
		chk("overwrite", d, 8'hC3);
		chk("still busy", {7'h00, core_busy_r}, 8'h01);
		wr(`ACS_OFF_SC, 8'h00);
		repeat (40) @(posedge sys_clk);
		rd(`ACS_OFF_RLO, d);
		k = starts;
		repeat (60) @(posedge sys_clk);
		chk("idle starts", 8'(starts - k), 8'h00);
		chk("idle busy", {7'h00, core_busy_r}, 8'h00);
		wr(`ACS_OFF_SC, 8'h00);
		wait_done();
		repeat (40) @(posedge sys_clk);
		chk("one start", 8'(starts - k), 8'h01);
		// Clear the flag left by the last run so the pin run is really waited for
		rd(`ACS_OFF_RLO, d);
		sample_val <= 10'h2F0;
		wr(`ACS_OFF_CLK, 8'h14);
		wr(`ACS_OFF_SC, 8'h00);
		repeat (100) @(posedge sys_clk);
		rd(`ACS_OFF_SC, d);
		chk("pin clock slow", d, 8'h00);
		wait_done();
		rd(`ACS_OFF_RLO, d);
		chk("pin clock data", d, 8'hF0);
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		end_sim();
	end
endmodule
